// *** hw/scl_pkg.sv ***
package scl_pkg;

  // system clock
  localparam int CLK_PERIOD_NS = 20;

  // driven configuration clock in master modes, slow rate
  localparam int CONFIG_CLOCK_SLOW_PERIOD_NS = 1600;
  // half period in system clocks, rounded down (longest time)
  localparam int CONFIG_CLOCK_HALF_CYC = CONFIG_CLOCK_SLOW_PERIOD_NS / 2 / CLK_PERIOD_NS;
  // fast-rate option multiplies the driven clock frequency
  localparam int FAST_FACTOR = 8;

  // init held low after a start, least time, rounded up
  localparam int CLEAR_NS = 1000;
  localparam int CLEAR_CYC = (CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // mode pin codes
  localparam logic [2:0] MODE_SLAVE_SERIAL = 3'h7;
  localparam logic [2:0] MODE_MASTER_SERIAL = 3'h0;
  localparam logic [2:0] MODE_PAR_DOWN = 3'h6;
  localparam logic [2:0] MODE_PAR_UP = 3'h4;

  // stream header and framing
  localparam int ONES_LEN = 8;
  localparam logic [3:0] PREAMBLE = 4'h2;
  localparam int LEN_BITS = 24;
  localparam int SEP_LEN = 4;
  localparam int CHECK_LEN = 4;
  localparam logic [3:0] FRAME_CHECK = 4'h6;
  localparam int POSTAMBLE_LEN = 7;
  localparam int STARTUP_CLOCKS = 4;
  localparam int FAST_START_BIT = 8;
  localparam int ADDR_BITS = 22;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INT_STATUS = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0C;
  localparam logic [7:0] REG_LENGTH = 8'h10;
  localparam logic [7:0] REG_FRAMES = 8'h14;

  // field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_EARLY_DONE_BIT = 1;
  localparam int INT_HDR_BIT = 0;
  localparam int INT_ERR_BIT = 1;
  localparam int INT_DONE_BIT = 2;

  // reset values
  localparam logic CTRL_EARLY_DONE_RST = 1'b0;
  localparam logic [2:0] INT_MASK_RST = 3'h0;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // loader states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_CLEAR = 4'h1,
    ST_WAIT_INIT = 4'h2,
    ST_SYNC = 4'h3,
    ST_LENGTH = 4'h4,
    ST_SEPARATOR = 4'h5,
    ST_FRAMES = 4'h6,
    ST_POSTAMBLE = 4'h7,
    ST_OVERFLOW = 4'h8,
    ST_STARTUP = 4'h9,
    ST_USER = 4'hA,
    ST_ERROR = 4'hB
  } scl_state_t;

  // one-cycle edge events of the configuration clock
  typedef struct packed {
    logic rise;
    logic fall;
  } scl_edge_t;

  // interrupt events, same layout as status and mask
  typedef struct packed {
    logic done;
    logic err;
    logic hdr;
  } scl_irq_t;

endpackage

// *** hw/scl_sync.sv ***
`timescale 1ns/1ps
module scl_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // asynchronous level in, synchronised level out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta; // first stage, read only by q
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  // plain two-stage shift
  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  // registers only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end

endmodule

// *** hw/scl_clkgen.sv ***
`timescale 1ns/1ps
module scl_clkgen #(
  parameter int HALF_CYC = scl_pkg::CONFIG_CLOCK_HALF_CYC,
  parameter int FACTOR = scl_pkg::FAST_FACTOR
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  input wire logic fast,
  // generated clock and its edges
  output logic clk_out,
  output scl_pkg::scl_edge_t edges
);

  localparam logic [15:0] SLOW_LAST = 16'(HALF_CYC - 1);
  localparam logic [15:0] FAST_LAST = 16'(HALF_CYC / FACTOR - 1);

  logic [15:0] cnt; // system clocks into this half period
  logic [15:0] next_cnt;
  logic next_clk;
  scl_pkg::scl_edge_t next_edges;

  // toggle at the end of each half period; stopped clock rests low
  always_comb begin
    next_cnt = cnt + 16'h0001;
    next_clk = clk_out;
    next_edges = '0;
    if (!run) begin
      next_cnt = '0;
      next_clk = 1'b0;
      // a pending high phase ends with a fall so the edges stay paired
      next_edges.fall = clk_out;
    end else if (cnt >= (fast ? FAST_LAST : SLOW_LAST)) begin
      next_cnt = '0;
      next_clk = !clk_out;
      next_edges.rise = !clk_out;
      next_edges.fall = clk_out;
    end
  end

  // registers only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= '0;
      clk_out <= 1'b0;
      edges <= '0;
    end else begin
      cnt <= next_cnt;
      clk_out <= next_clk;
      edges <= next_edges;
    end
  end

endmodule

// *** hw/scl_top.sv ***
// Overview of operation
// - slave serial: sample data on external clock rise
// - pass preamble and overflow bits to chain output
// - slave serial chain output changes half period later
// - mode pins 111 select slave serial
// - mode pins weakly pulled up during configuration
// - master serial: drive clock, capture on next rise
// - master serial chain output lags one and half periods
// - fast-rate option speeds driven clock eight times
// - mode pins 000 select master serial
// - low-during-config stays high after configuration
// - early done option asserts done before startup
// - parallel: first byte loads as read strobe ends
// - stream: ones, preamble, 24-bit length, separator, frames
// - frame check error suspends loading, pulls init low
`timescale 1ns/1ps
module scl_top #(
  parameter int ADDR_W = 8,
  parameter int FRAME_LEN = 16,
  parameter int NUM_FRAMES = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // mode pins
  input wire logic [2:0] mode_select_pins,
  output logic mode_pullup_en,
  // serial data and daisy chain
  input wire logic din,
  output logic dout,
  // configuration clock, two-way pin
  input wire logic config_clock_in,
  output logic config_clock_out,
  output logic config_clock_oe_n,
  // init status, open drain
  input wire logic init_in,
  output logic init_out,
  output logic init_oe_n,
  // completion and boot memory enable
  output logic done,
  output logic low_during_config,
  // parallel memory
  output logic read_strobe_n,
  output logic [scl_pkg::ADDR_BITS-1:0] address,
  input wire logic [7:0] data_byte,
  // interrupt
  output logic irq
);

  localparam int FLAST = FRAME_LEN + scl_pkg::CHECK_LEN;

  // synchronised pins
  logic [2:0] mode_s;
  logic din_s;
  logic cc_s;
  logic init_s;
  logic [7:0] byte_s;
  logic cc_prev; // previous synced external clock level

  // loader state
  scl_pkg::scl_state_t state, next_state;
  scl_pkg::scl_irq_t ev, next_ev; // one-cycle event pulses
  logic [23:0] cnt, next_cnt; // field position or clear timer
  logic [23:0] tot, next_tot; // bits seen since sync began
  logic [23:0] len, next_len; // length count from header
  logic [15:0] frame, next_frame; // frames checked so far
  logic [11:0] shreg, next_shreg; // recent bits, pattern match
  logic [2:0] mode, next_mode; // mode caught at start
  logic fast, next_fast;
  logic fast_opt, next_fast_opt;
  logic next_done, next_ldc, next_init_oe_n;

  // chain and parallel datapath
  logic st1, next_st1, st2, next_st2, next_dout;
  logic [7:0] pshift, next_pshift;
  logic [2:0] pcnt, next_pcnt;
  logic next_strobe_n;
  logic [scl_pkg::ADDR_BITS-1:0] next_address;
  logic next_pullup, next_cc_oe_n;

  // register file and bus
  logic start, next_start; // one-cycle start request
  logic early_done, next_early_done;
  scl_pkg::scl_irq_t ist, next_ist, imask, next_imask;
  logic aw_got, next_aw_got, w_got, next_w_got;
  logic [ADDR_W-1:0] awaddr, next_awaddr;
  logic [31:0] wdata, next_wdata;
  logic [3:0] wstrb, next_wstrb;
  logic next_awready, next_wready, next_bvalid, next_arready;
  logic next_rvalid, next_irq;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // clock generator hookup
  logic gen_run;
  logic gen_clk;
  scl_pkg::scl_edge_t gen_ev;

  // derived views
  logic master, par, slave, running, fwd, bit_ev, fall_ev, bit_val;

  // every pin from outside passes two flops first
  scl_sync #(.WIDTH(14)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({mode_select_pins, din, config_clock_in, init_in, data_byte}),
    .q({mode_s, din_s, cc_s, init_s, byte_s})
  );

  // driven clock, runs on through an error so the address keeps moving
  scl_clkgen u_clkgen (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(gen_run),
    .fast(fast),
    .clk_out(gen_clk),
    .edges(gen_ev)
  );

  // address decode shared by reads and writes
  function automatic logic reg_known(input logic [ADDR_W-1:0] a);
    logic [7:0] o;
    o = 8'(a);
    reg_known = (o == scl_pkg::REG_CTRL) || (o == scl_pkg::REG_STATUS) ||
      (o == scl_pkg::REG_INT_STATUS) || (o == scl_pkg::REG_INT_MASK) ||
      (o == scl_pkg::REG_LENGTH) || (o == scl_pkg::REG_FRAMES);
  endfunction

  // mode and edge selection
  always_comb begin
    slave = (mode == scl_pkg::MODE_SLAVE_SERIAL);
    par = (mode == scl_pkg::MODE_PAR_DOWN) || (mode == scl_pkg::MODE_PAR_UP);
    master = (mode == scl_pkg::MODE_MASTER_SERIAL) || par;
    running = (state >= scl_pkg::ST_SYNC && state <= scl_pkg::ST_STARTUP) ||
      state == scl_pkg::ST_ERROR;
    gen_run = master && running;
    // slave uses the edges of the external clock
    bit_ev = slave ? (cc_s && !cc_prev) : gen_ev.rise;
    fall_ev = slave ? (!cc_s && cc_prev) : gen_ev.fall;
    // parallel takes D0 first from the byte being loaded
    if (par) begin
      bit_val = read_strobe_n ? pshift[0] : byte_s[0];
    end else begin
      bit_val = din_s;
    end
    // header and overflow go down the chain, own frames do not
    fwd = (state >= scl_pkg::ST_SYNC && state <= scl_pkg::ST_SEPARATOR) ||
      state == scl_pkg::ST_OVERFLOW || state == scl_pkg::ST_STARTUP;
  end

  // loader sequence: next values
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_tot = tot;
    next_len = len;
    next_frame = frame;
    next_shreg = shreg;
    next_mode = mode;
    next_fast = fast;
    next_fast_opt = fast_opt;
    next_done = done;
    next_ldc = low_during_config;
    next_init_oe_n = 1'b1;
    next_ev = '0;
    if (start) begin
      // restart from anywhere; mode pins caught here
      next_state = scl_pkg::ST_CLEAR;
      next_cnt = '0;
      next_tot = '0;
      next_len = '0;
      next_frame = '0;
      next_shreg = '0;
      next_mode = mode_s;
      next_fast = 1'b0;
      next_fast_opt = 1'b0;
      next_done = 1'b0;
      next_ldc = 1'b0;
    end else begin
      if (bit_ev && state >= scl_pkg::ST_SYNC &&
          state <= scl_pkg::ST_STARTUP) begin
        next_tot = tot + 24'h000001;
        next_shreg = {shreg[10:0], bit_val};
        next_cnt = cnt + 24'h000001;
      end
      unique case (state)
        scl_pkg::ST_IDLE: begin
          next_cnt = '0;
        end
        scl_pkg::ST_CLEAR: begin
          // init low while the memory clears, timed on aclk
          next_init_oe_n = 1'b0;
          next_cnt = cnt + 24'h000001;
          if (cnt == 24'(scl_pkg::CLEAR_CYC - 1)) begin
            next_state = scl_pkg::ST_WAIT_INIT;
          end
        end
        scl_pkg::ST_WAIT_INIT: begin
          // the whole chain must have released init
          next_cnt = '0;
          if (init_s) begin
            next_state = scl_pkg::ST_SYNC;
          end
        end
        scl_pkg::ST_SYNC: begin
          // extra leading ones are tolerated
          if (bit_ev && {shreg[10:0], bit_val} ==
              {8'hFF, scl_pkg::PREAMBLE}) begin
            next_state = scl_pkg::ST_LENGTH;
            next_cnt = '0;
            next_ev.hdr = 1'b1;
          end
        end
        scl_pkg::ST_LENGTH: begin
          if (bit_ev) begin
            next_len = {len[22:0], bit_val};
            if (cnt == 24'(scl_pkg::LEN_BITS - 1)) begin
              next_state = scl_pkg::ST_SEPARATOR;
              next_cnt = '0;
            end
          end
        end
        scl_pkg::ST_SEPARATOR: begin
          if (bit_ev && cnt == 24'(scl_pkg::SEP_LEN - 1)) begin
            next_state = scl_pkg::ST_FRAMES;
            next_cnt = '0;
          end
        end
        scl_pkg::ST_FRAMES: begin
          if (bit_ev) begin
            // first data bit of frame zero carries the fast-rate option
            if (frame == 16'h0000 && cnt == 24'h000001) begin
              next_fast_opt = bit_val;
            end
            if (frame == 16'h0000 && fast_opt &&
                cnt == 24'(scl_pkg::FAST_START_BIT)) begin
              next_fast = 1'b1;
            end
            if (cnt == 24'(FLAST)) begin
              next_cnt = '0;
              next_frame = frame + 16'h0001;
              if (next_shreg[3:0] != scl_pkg::FRAME_CHECK) begin
                next_state = scl_pkg::ST_ERROR;
                next_ev.err = 1'b1;
              end else if (frame == 16'(NUM_FRAMES - 1)) begin
                next_state = scl_pkg::ST_POSTAMBLE;
              end
            end
          end
        end
        scl_pkg::ST_POSTAMBLE: begin
          if (bit_ev && cnt == 24'(scl_pkg::POSTAMBLE_LEN - 1)) begin
            next_state = scl_pkg::ST_OVERFLOW;
          end
        end
        scl_pkg::ST_OVERFLOW: begin
          // keep clocking until the length count covers the chain
          if (bit_ev && next_tot >= len) begin
            next_state = scl_pkg::ST_STARTUP;
            next_cnt = '0;
            next_done = early_done;
          end
        end
        scl_pkg::ST_STARTUP: begin
          if (bit_ev && cnt == 24'(scl_pkg::STARTUP_CLOCKS - 1)) begin
            next_state = scl_pkg::ST_USER;
            next_done = 1'b1;
            next_ldc = 1'b1;
            next_ev.done = 1'b1;
          end
        end
        scl_pkg::ST_USER: begin
          next_cnt = '0;
        end
        scl_pkg::ST_ERROR: begin
          // loading suspended until software restarts
          next_init_oe_n = 1'b0;
          next_cnt = '0;
          next_tot = tot;
          next_shreg = shreg;
        end
        default: begin
          next_state = scl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // chain output pipe and parallel reader: next values
  always_comb begin
    next_st1 = st1;
    next_st2 = st2;
    next_dout = dout;
    next_pshift = pshift;
    next_pcnt = pcnt;
    next_strobe_n = read_strobe_n;
    next_address = address;
    // follow the next state so the pull-ups return with the restart
    next_pullup = (next_state != scl_pkg::ST_USER);
    next_cc_oe_n = !(master && state != scl_pkg::ST_IDLE);
    if (bit_ev) begin
      next_st1 = fwd ? bit_val : 1'b1;
      next_st2 = st1;
    end
    // slave emits one stage after the rise, master two
    if (fall_ev) begin
      next_dout = slave ? st1 : st2;
    end
    if (par && running && bit_ev) begin
      if (!read_strobe_n) begin
        // byte lands as the strobe cycle ends
        next_pshift = {1'b0, byte_s[7:1]};
        next_strobe_n = 1'b1;
        next_pcnt = 3'h1;
        next_address = (mode == scl_pkg::MODE_PAR_DOWN) ?
          address - 22'h000001 : address + 22'h000001;
      end else begin
        next_pshift = {1'b0, pshift[7:1]};
        next_pcnt = pcnt + 3'h1;
      end
    end
    if (par && running && fall_ev && read_strobe_n && pcnt == 3'h0) begin
      next_strobe_n = 1'b0;
    end
    if (start) begin
      // first strobe cycle opens as soon as loading begins
      next_st1 = 1'b1;
      next_st2 = 1'b1;
      next_dout = 1'b1;
      next_pcnt = 3'h0;
      next_strobe_n = !((mode_s == scl_pkg::MODE_PAR_DOWN) ||
        (mode_s == scl_pkg::MODE_PAR_UP));
      next_address = (mode_s == scl_pkg::MODE_PAR_DOWN) ? '1 : '0;
    end
  end

  // axi4-lite slave and register file: next values
  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_awaddr = awaddr;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_start = 1'b0;
    next_early_done = early_done;
    next_imask = imask;
    next_ist = ist | ev; // events set, below a write may clear
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_wdata = s_axi_wdata;
      next_wstrb = s_axi_wstrb;
    end
    if (aw_got && w_got && !s_axi_bvalid) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = reg_known(awaddr) ? scl_pkg::RESP_OKAY :
        scl_pkg::RESP_SLVERR;
      if (wstrb[0]) begin
        unique case (8'(awaddr))
          scl_pkg::REG_CTRL: begin
            next_start = wdata[scl_pkg::CTRL_START_BIT];
            next_early_done = wdata[scl_pkg::CTRL_EARLY_DONE_BIT];
          end
          // set wins: events of this cycle survive the clear
          scl_pkg::REG_INT_STATUS: next_ist = (ist & ~wdata[2:0]) | ev;
          scl_pkg::REG_INT_MASK: next_imask = wdata[2:0];
          default: begin
          end
        endcase
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready = !next_w_got && !next_bvalid;
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = reg_known(s_axi_araddr) ? scl_pkg::RESP_OKAY :
        scl_pkg::RESP_SLVERR;
      unique case (8'(s_axi_araddr))
        scl_pkg::REG_CTRL: next_rdata = {30'h0, early_done, 1'b0};
        scl_pkg::REG_STATUS: next_rdata = {22'h0, fast, init_s,
          done, mode, state};
        scl_pkg::REG_INT_STATUS: next_rdata = {29'h0, ist};
        scl_pkg::REG_INT_MASK: next_rdata = {29'h0, imask};
        scl_pkg::REG_LENGTH: next_rdata = {8'h0, len};
        scl_pkg::REG_FRAMES: next_rdata = {16'h0, frame};
        default: next_rdata = 32'h0;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    next_irq = |(next_ist & next_imask);
  end

  // all state registers; the reset and the next values here, except arready, which picks next_arready or !next_rvalid, and cc_prev, init_out, config_clock_out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= scl_pkg::ST_IDLE;
      ev <= '0;
      cnt <= '0;
      tot <= '0;
      len <= '0;
      frame <= '0;
      shreg <= '0;
      mode <= scl_pkg::MODE_SLAVE_SERIAL;
      fast <= 1'b0;
      fast_opt <= 1'b0;
      done <= 1'b0;
      low_during_config <= 1'b0;
      init_oe_n <= 1'b1;
      init_out <= 1'b0;
      cc_prev <= 1'b0;
      st1 <= 1'b1;
      st2 <= 1'b1;
      dout <= 1'b1;
      pshift <= '0;
      pcnt <= '0;
      read_strobe_n <= 1'b1;
      address <= '0;
      mode_pullup_en <= 1'b1;
      config_clock_oe_n <= 1'b1;
      config_clock_out <= 1'b0;
      start <= 1'b0;
      early_done <= scl_pkg::CTRL_EARLY_DONE_RST;
      ist <= '0;
      imask <= scl_pkg::INT_MASK_RST;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awaddr <= '0;
      wdata <= '0;
      wstrb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= scl_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= scl_pkg::RESP_OKAY;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      ev <= next_ev;
      cnt <= next_cnt;
      tot <= next_tot;
      len <= next_len;
      frame <= next_frame;
      shreg <= next_shreg;
      mode <= next_mode;
      fast <= next_fast;
      fast_opt <= next_fast_opt;
      done <= next_done;
      low_during_config <= next_ldc;
      init_oe_n <= next_init_oe_n;
      init_out <= 1'b0;
      cc_prev <= cc_s;
      st1 <= next_st1;
      st2 <= next_st2;
      dout <= next_dout;
      pshift <= next_pshift;
      pcnt <= next_pcnt;
      read_strobe_n <= next_strobe_n;
      address <= next_address;
      mode_pullup_en <= next_pullup;
      config_clock_oe_n <= next_cc_oe_n;
      config_clock_out <= gen_clk; // one flop behind gen_clk and its edges
      start <= next_start;
      early_done <= next_early_done;
      ist <= next_ist;
      imask <= next_imask;
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      awaddr <= next_awaddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= (s_axi_rvalid || s_axi_arvalid) ? next_arready :
        !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      irq <= next_irq;
    end
  end

endmodule

// *** test/scl_top_asserts.sv ***
`timescale 1ns/1ps
module scl_top_asserts (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // configuration status
  input wire logic done,
  input wire logic low_during_config,
  input wire logic init_oe_n,
  input wire logic mode_pullup_en,
  // configuration clock pin
  input wire logic config_clock_oe_n,
  input wire logic config_clock_out,
  // bus handshakes
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_awready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_arready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // pull-ups stay on until the device reaches user operation
  a_pull_cfg: assert property (
    !low_during_config |-> mode_pullup_en)
    else $error("pull-up off while configuring");
  a_clk_rest: assert property (
    config_clock_oe_n |-> !config_clock_out)
    else $error("clock moves while not driven");
  a_ldc_done: assert property (low_during_config |-> done)
    else $error("config signal high without done");
  a_init_done: assert property (!init_oe_n ##1 !init_oe_n |-> !done)
    else $error("done while init pulled low");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped early");
  a_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("awready during response");
  a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during response");
endmodule
bind scl_top scl_top_asserts u_chk (.*);

// *** test/scl_mem.sv ***
`timescale 1ns/1ps
module scl_mem (
  // driven clock, mode and stream
  input wire logic clk_m, ext, en,
  input wire logic [199:0] bits,
  input wire logic [21:0] address,
  // serial data, parallel byte and own clock
  output logic din, clk_s,
  output logic [7:0] data_byte
);
  int i = 0;
  // released line shows the inverse of the stream head
  assign din = en ? bits[199-i] : ~bits[199];
  // upstream device clock, still unless ext and en are both high
  initial begin
    clk_s = 0;
    #7;
    forever #80 clk_s = ext && en && !clk_s;
  end
  // next bit after each fall of our own clock
  always @(negedge clk_s) if (en && i < 199) i <= i + 1;
  // boot memory steps after each driven rise, with output delay
  always @(posedge clk_m) if (!ext && en && i < 199) i <= #30 i + 1;
  always @(negedge en) i <= 0;
  // parallel memory: byte per address, first stream bit on D0
  always @* for (int b = 0; b < 8; b++)
    data_byte[b] = bits[199 - 8 * address - b];
endmodule

// *** test/test_scl_top.sv ***
`timescale 1ns/1ps
module test_scl_top;
  logic aclk = 0, aresetn = 0, ext = 1, en = 0, clk_s;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, data_byte;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, din, dout, irq, done;
  logic [2:0] mode_select_pins = 3'h7;
  logic config_clock_in, config_clock_out, config_clock_oe_n, init_in;
  logic init_out, init_oe_n, low_during_config, read_strobe_n;
  logic mode_pullup_en;
  logic [21:0] address;
  logic [199:0] bits = '1;
  int fails = 0, comparisons = 0, n, r = 0;
  logic [7:0] ovf = 0;
  // downstream device: takes the chain output on each slave clock rise,
  // rises 132 to 139 carry the overflow byte of the slave stream
  always @(posedge clk_s) begin
    r <= r + 1;
    if (r >= 132 && r < 140) ovf <= {ovf[6:0], dout};
  end
  // wired clock pin and pulled-up init line
  assign config_clock_in = config_clock_oe_n ? clk_s : config_clock_out;
  assign init_in = init_oe_n ? 1'b1 : init_out;
  scl_top DUT (.*);
  scl_mem u_mem (.clk_m(config_clock_out), .ext, .en, .bits, .address,
    .din, .clk_s, .data_byte);
  initial forever #10 aclk = ~aclk;
  task final_report;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  // one edge of a bounded wait
  task tick;
    @(posedge aclk);
    if (++n > 20000) begin
      fails++;
      final_report;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    n = 0;
    tick;
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    do begin
      tick;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp; s_axi_bready <= 0;
  endtask
  task rd(input logic [7:0] a);
    n = 0;
    tick;
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      tick;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata; rs = s_axi_rresp; s_axi_rready <= 0;
  endtask
  // header, four frames, postamble, random overflow, then ones
  function automatic logic [199:0] mk(input logic [63:0] f, logic bad);
    logic [199:0] s = '1;
    s[199:160] = {8'hFF, scl_pkg::PREAMBLE, 24'd139, 4'hF};
    for (int k = 0; k < 4; k++)
      s[159-21*k -: 21] = {1'b0, f[16*k +: 16],
        (bad && k == 2) ? 4'h0 : scl_pkg::FRAME_CHECK};
    s[75:61] = {7'h3F, 8'($urandom)};
    return s;
  endfunction
  initial begin
    v = $urandom(32'hE5D43982);
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    rd(scl_pkg::REG_INT_MASK); chk("mask", 0, v);
    rd(8'h40); chk("unmapped", scl_pkg::RESP_SLVERR, rs);
    wr(scl_pkg::REG_INT_MASK, 7);
    // slave serial, master serial at fast rate with a bad frame, parallel up
    for (int t = 0; t < 3; t++) begin
      ext <= t == 0;
      mode_select_pins <= t[1] ? 3'h4 : t ? 3'h0 : 3'h7;
      bits <= mk({$urandom, $urandom} & 64'hFFFFFFFFFFFF7FFF |
        64'(t == 1) << 15, t == 1);
      wr(scl_pkg::REG_CTRL, 1);
      repeat (scl_pkg::CLEAR_CYC + 8) tick;
      en <= 1;
      n = 0;
      if (t == 1) begin
        do tick; while (init_oe_n);
        chk("err done", 0, done);
        rd(scl_pkg::REG_INT_STATUS); chk("err", 3, v);
        chk("clock", 0, config_clock_oe_n);
        rd(scl_pkg::REG_STATUS); chk("status", 32'h20B, v);
      end else begin
        do tick; while (!low_during_config);
        chk("done", 1, done);
        rd(scl_pkg::REG_LENGTH); chk("len", 139, v);
        rd(scl_pkg::REG_FRAMES); chk("frames", 4, v);
        if (t == 0) chk("overflow", bits[68:61], ovf);
        else chk("address", 18, address);
        chk("irq", 1, irq);
        wr(scl_pkg::REG_INT_STATUS, 7); chk("irq clr", 0, irq);
      end
      en <= 0;
      $display("test %0d done", t);
    end
    final_report;
  end
endmodule
